//--- include/ucar_pkg.sv
// types shared by the channel aux register block
package ucar_pkg;
  typedef enum logic [1:0] {UCAR_TRIGGERED, UCAR_PERIODIC, UCAR_ONESHOT, UCAR_TRIG_PERIODIC} ucar_mode_t;
  typedef enum {UCAR_DMA_IDLE, UCAR_DMA_DESC, UCAR_DMA_WAIT, UCAR_DMA_BLOCK} ucar_dma_state_t;
  typedef enum {UCAR_PG_IDLE, UCAR_PG_DELAY, UCAR_PG_ACTIVE, UCAR_PG_REST} ucar_pg_state_t;
endpackage

//--- include/ucar_regs.svh
// register offsets, field positions and reset values of the channel aux registers
`ifndef UCAR_REGS_SVH
`define UCAR_REGS_SVH
`define UCAR_OFS_TX_RAM_OFFSETS 12'h018
`define UCAR_OFS_DMA_PTR 12'h01c
`define UCAR_OFS_START_ADDR 12'h020
`define UCAR_OFS_TRIG 12'h024
`define UCAR_OFS_PULSE 12'h028
`define UCAR_OFS_TX_CTRL 12'h02c
`define UCAR_OFS_DMA_STATUS 12'h030
`define UCAR_OFS_TRIG_STATUS 12'h034
`define UCAR_TXO_IO_LSB 0
`define UCAR_TXO_DMA_LSB 16
`define UCAR_RXO_DMA_LSB 16
`define UCAR_ADDR_RX_STB 16
`define UCAR_ADDR_TX_STB 17
`define UCAR_TRIG_HMAX_STB 22
`define UCAR_TRIG_HMIN_STB 23
`define UCAR_TRIG_LMAX_STB 24
`define UCAR_TRIG_LMIN_STB 25
`define UCAR_LEVEL_BIT 23
`define UCAR_PULSE_DLY_STB 22
`define UCAR_PULSE_PER_STB 23
`define UCAR_PULSE_DUTY_STB 24
`define UCAR_TXC_WR_MASK 32'h0000_fffe
`define UCAR_TXC_RESET 32'h0000_0000
`define UCAR_CNT_RESET 22'h00_0000
`define UCAR_DESC_EOC_BIT 0
`endif

//--- sim/test_uart_channel_aux_registers.sv
// self-checking bench of the channel aux register bank
`timescale 1ns/10ps
`include "ucar_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_uart_channel_aux_registers;
  logic clk_sys_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, tms = 0, twf = 0, ten = 0;
  logic tdw = 0, rww = 0, rdw = 0, trig = 0, pready, ack, done, req, bst, busy, dout, perr;
  logic [11:0] pa = 0, txio, m_tx, m_txd;
  logic [10:0] rxio, m_rx, m_rxd;
  logic [31:0] pw = 0, pr, rd, da, bh, bl, bn, tc, r, w;
  logic [95:0] xq[$], x; // expected host, local, length per block
  logic [1:0] lat = 0;
  int mismatches = 0, checks = 0, cyc = 0, nblk = 0, n;
  always #5 clk_sys_i = ~clk_sys_i;
  ucar_regs ucar_regs_inst (.clk_sys_i, .arst_n_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pw), .prdata_o(pr), .pready_o(pready), .pslverr_o(perr), .tx_msg_start_i(tms),
    .tx_word_fetch_i(twf), .tx_enabled_i(ten), .tx_io_addr_o(txio), .tx_dma_word_i(tdw),
    .rx_word_wr_i(rww), .rx_io_addr_o(rxio), .rx_dma_word_i(rdw), .dma_req_o(req), .dma_addr_o(da),
    .dma_ack_i(ack), .dma_rdata_i(rd), .blk_done_i(done), .blk_start_o(bst), .blk_host_o(bh),
    .blk_local_o(bl), .blk_len_o(bn), .dma_busy_o(busy), .trig_pin_i(trig), .dscrt_out_o(dout),
    .tx_ctrl_o(tc));
  ucar_dma_mem ucar_dma_mem_inst (.clk_sys_i, .arst_n_i, .dma_req_i(req), .dma_addr_i(da),
    .blk_start_i(bst), .lat_i(lat), .dma_ack_o(ack), .dma_rdata_o(rd), .blk_done_o(done));
  // one apb transfer, entered just after an edge; an idle edge follows
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    {psel, pen, pwr, pa, pw} <= {2'b10, wr, a, d};
    @(posedge clk_sys_i) pen <= 1;
    do @(posedge clk_sys_i) n++; while (pready !== 1'b1 && n < 20);
    r = pr;
    mismatches += (n >= 20 || perr !== 1'b0);
    {psel, pen} <= 2'b00;
    @(posedge clk_sys_i);
  endtask
  // count active-low output cycles over a fixed window
  task meas();
    n = 0;
    repeat (400) @(posedge clk_sys_i) n += (dout === 1'b0);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard and block-start monitor against the expected queue
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      give_verdict();
    end
    if (bst === 1'b1) begin
      nblk++;
      x = xq.pop_front();
      `CHK({bh, bl, bn}, x)
    end
  end
  initial begin
    w = $urandom(32'h0000_c7b5);
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1;
    @(posedge clk_sys_i);
    apb(0, 12'h018, 0);
    `CHK(r, 32'h0000_0000)
    apb(0, 12'h02c, 0);
    `CHK(r, 32'h0000_0000)
    $display("test reset done");
    // start addresses, a strobe-less write, then three pointer steps
    w = $urandom;
    {m_rx, m_tx, m_txd, m_rxd} = {w[10:0], w[11:0], 12'h003, 11'h003};
    apb(1, 12'h020, {14'h0, 2'b11, w[15:0]});
    apb(1, 12'h020, {16'h0, ~w[15:0]});
    tms <= 1;
    @(posedge clk_sys_i) tms <= 0;
    repeat (3) begin
      @(posedge clk_sys_i) {twf, tdw, rww, rdw} <= 4'hf;
      @(posedge clk_sys_i) {twf, tdw, rww, rdw} <= 4'h0;
    end
    {m_tx, m_rx} = {m_tx + 12'h003, m_rx + 11'h003};
    apb(0, 12'h018, 0);
    `CHK(r, {4'h0, m_txd, 4'h0, m_tx})
    apb(0, 12'h01c, 0);
    `CHK(r, {5'h0, m_rxd, 5'h0, m_rx})
    `CHK(txio, m_tx)
    `CHK(rxio, m_rx)
    $display("test addresses done");
    repeat (3) begin
      w = $urandom;
      ten <= w[31];
      apb(1, 12'h02c, w);
      apb(0, 12'h02c, 0);
      `CHK(r, w & `UCAR_TXC_WR_MASK | {31'h0, ten})
      `CHK(tc, w & `UCAR_TXC_WR_MASK)
    end
    apb(1, 12'h040, 32'hffff_ffff);
    apb(0, 12'h040, 0);
    `CHK(r | tc[0], 32'h0000_0000)
    $display("test control done");
    // two-block chain, then a zero write during a slow fetch
    lat <= 2'($urandom);
    xq = '{{32'h1000, 32'h10, 32'h40}, {32'h2000, 32'h20, 32'h80}};
    apb(1, 12'h01c, 32'h0000_0100);
    repeat (80) @(posedge clk_sys_i);
    `CHK({nblk, busy, req}, {32'd2, 2'b00})
    lat <= 3;
    apb(1, 12'h01c, 32'h0000_0200);
    apb(1, 12'h01c, 32'h0000_0000);
    `CHK(busy, 1'b0)
    repeat (40) @(posedge clk_sys_i);
    `CHK(nblk, 2)
    $display("test dma done");
    // limits, then a 40-cycle high and 40-cycle low, i.e. 10 ticks each
    for (int i = 0; i < 4; i++) apb(1, 12'h024, {6'h0, 4'(1 << i), i[1] ? 22'h14 : 22'h3});
    trig <= 1;
    repeat (20) @(posedge clk_sys_i);
    apb(1, 12'h034, 0);
    repeat (17) @(posedge clk_sys_i);
    trig <= 0;
    repeat (40) @(posedge clk_sys_i);
    trig <= 1;
    repeat (12) @(posedge clk_sys_i);
    apb(0, 12'h024, 0);
    `CHK(r, 32'h0080_000a)
    apb(0, 12'h028, 0);
    `CHK(r, 32'h0080_000a)
    apb(0, 12'h034, 0);
    `CHK(r[3:0], 4'b1001)
    $display("test trigger done");
    // periodic output: period 10, duty 3, then duty 20 falls back to half
    apb(1, 12'h028, 32'h0080_000a);
    apb(1, 12'h028, 32'h0100_0003);
    apb(1, 12'h02c, 32'h0000_2400);
    meas();
    `CHK(n > 100 && n < 140, 1'b1)
    apb(1, 12'h028, 32'h0100_0014);
    meas();
    `CHK(n > 180 && n < 220, 1'b1)
    $display("test pulse done");
    // forced steady level, then triggered mode: rising trigger, five-tick delay
    trig <= 0;
    apb(1, 12'h02c, 32'h0000_9000);
    apb(1, 12'h028, 32'h0040_0005);
    `CHK(dout, 1'b0)
    apb(1, 12'h02c, 32'h0000_0c00);
    trig <= 1;
    repeat (12) @(posedge clk_sys_i);
    `CHK(dout, 1'b1)
    repeat (12) @(posedge clk_sys_i);
    `CHK(dout, 1'b1)
    repeat (4) @(posedge clk_sys_i);
    `CHK(dout, 1'b0)
    $display("test trigger mode done");
    give_verdict();
  end
endmodule // test_uart_channel_aux_registers

//--- sim/ucar_dma_mem.sv
// dma memory model: descriptor chain store and block mover
`timescale 1ns/10ps
module ucar_dma_mem (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic dma_req_i,
  input wire logic [31:0] dma_addr_i,
  input wire logic blk_start_i,
  input wire logic [1:0] lat_i, // extra answer cycles, 0 is prompt
  output logic dma_ack_o,
  output logic [31:0] dma_rdata_o,
  output logic blk_done_o
);
  logic [31:0] mem [logic [31:0]]; // descriptor words by byte address
  int wcnt; // cycles waited on this word
  int mcnt; // cycles left of a block move
  // buffer, local, length, next: second chain entry ends it
  initial begin
    mem = '{32'h100: 32'h1000, 32'h104: 32'h10, 32'h108: 32'h40, 32'h10c: 32'h200,
      32'h200: 32'h2000, 32'h204: 32'h20, 32'h208: 32'h80, 32'h20c: 32'h1};
  end
  // answer each word after lat_i cycles; data toggles when not valid
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {dma_ack_o, blk_done_o, wcnt, mcnt} <= '0;
      dma_rdata_o <= '0;
    end else begin
      dma_ack_o <= 1'b0;
      dma_rdata_o <= ~dma_rdata_o;
      blk_done_o <= (mcnt == 1);
      mcnt <= blk_start_i ? 6 : (mcnt > 0 ? mcnt - 1 : 0);
      if (dma_req_i && !dma_ack_o) begin
        wcnt <= (wcnt >= lat_i) ? 0 : wcnt + 1;
        dma_ack_o <= (wcnt >= lat_i);
        if (wcnt >= lat_i) begin
          dma_rdata_o <= mem.exists(dma_addr_i) ? mem[dma_addr_i] : 32'h0000_0000;
        end
      end
    end
  end
endmodule // ucar_dma_mem

//--- src/ucar_pulse_gen.sv
// discrete output pulse generator on the pll clock b enable
`timescale 1ns/10ps
`include "ucar_regs.svh"
module ucar_pulse_gen import ucar_pkg::*; #(
  parameter int CW = 22
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic trig_edge_i,
  input wire logic [1:0] mode_i,
  input wire logic [CW-1:0] delay_i,
  input wire logic [CW-1:0] period_i,
  input wire logic [CW-1:0] duty_i,
  output logic active_o
);
  ucar_pg_state_t state; // generator phase
  logic [CW-1:0] cnt; // ticks spent in phase; rest keeps counting on from the start of active
  logic [CW-1:0] width; // effective active length
  logic triggered;
  assign triggered = (mode_i == UCAR_TRIGGERED) || (mode_i == UCAR_TRIG_PERIODIC);
  // half period when duty would overrun the period
  assign width = (duty_i > period_i) ? (period_i >> 1) : duty_i;

  // phase sequencer, advances only on ticks
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= UCAR_PG_IDLE;
      cnt <= `UCAR_CNT_RESET;
    end else if (!enable_i) begin
      state <= UCAR_PG_IDLE;
      cnt <= `UCAR_CNT_RESET;
    end else if (tick_i) begin
      cnt <= cnt + 1'b1;
      unique case (state)
        UCAR_PG_IDLE: begin
          cnt <= `UCAR_CNT_RESET;
          if (!triggered || trig_edge_i) begin
            state <= triggered ? UCAR_PG_DELAY : UCAR_PG_ACTIVE;
          end
        end
        UCAR_PG_DELAY: begin
          if (cnt + 1'b1 >= delay_i) begin
            state <= UCAR_PG_ACTIVE;
            cnt <= `UCAR_CNT_RESET;
          end
        end
        UCAR_PG_ACTIVE: begin
          if (cnt + 1'b1 >= width) begin
            state <= UCAR_PG_REST;
          end
        end
        UCAR_PG_REST: begin
          // period runs from the start of the active phase
          if (cnt + 1'b1 >= period_i) begin
            cnt <= `UCAR_CNT_RESET;
            if (mode_i == UCAR_PERIODIC || mode_i == UCAR_TRIG_PERIODIC) begin
              state <= UCAR_PG_ACTIVE;
            end else if (mode_i == UCAR_TRIGGERED) begin
              state <= UCAR_PG_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign active_o = (state == UCAR_PG_ACTIVE);

  a_no_early_pulse: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (state == UCAR_PG_DELAY && tick_i && cnt + 1'b1 < delay_i && enable_i) |=> !active_o)
    else $error("pulse asserted before delay expired");
  a_duty_clamp: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (state == UCAR_PG_ACTIVE && tick_i && enable_i && duty_i > period_i && cnt + 1'b1 >= (period_i >> 1))
    |=> !active_o) else $error("duty clamp wrong");
  c_pulse_seen: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(active_o));
endmodule // ucar_pulse_gen

//--- src/ucar_regs.sv
// channel aux register bank: apb slave, ram pointers, read dma chain, trigger and pulse
//
// Functional notes
// - report transmit serialiser fetch offset, bits 11-0
// - report transmit dma deposit offset, bits 27-16
// - pointer write starts descriptor fetch of four
// - follow next pointers until end-of-chain bit
// - writing zero aborts active read dma
// - receive offsets: io low, dma upper
// - rx strobe loads receive ram counter
// - status word first, data after, messages successive
// - receive address uses low eleven bits
// - tx strobe latches, reloads counter per message
// - transmit address uses low twelve bits
// - trigger limit port carries 22-bit count
// - strobes 22-25 select hmax, hmin, lmax, lmin
// - compare durations against limits, latch flags
// - high duration readback with live level
// - low duration readback with live level
// - pulse params: delay, period, duty strobes
// - triggered mode waits delay then asserts
// - period sets interval between assertions
// - duty over period falls back to half
// - tx control enabled bit read-only, bits 15-1 writable, bits 31-16 read zero
// - tx control holds framing bits 4-7
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "ucar_regs.svh"
module ucar_regs import ucar_pkg::*; #(
  parameter int CW = 22, // trigger and pulse count width
  parameter int TX_AW = 12, // transmit ram address width
  parameter int RX_AW = 11, // receive ram address width
  parameter int BDIV = 4 // sys cycles per pll clock b period
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // transmit serialiser side
  input wire logic tx_msg_start_i, // pulse: new message begins
  input wire logic tx_word_fetch_i, // pulse: a word was fetched
  input wire logic tx_enabled_i, // serialiser state
  output logic [TX_AW-1:0] tx_io_addr_o,
  // transmit dma write side
  input wire logic tx_dma_word_i, // pulse: dma deposited a word
  // receiver side
  input wire logic rx_word_wr_i, // pulse: status or data word written
  output logic [RX_AW-1:0] rx_io_addr_o,
  // read dma reader side
  input wire logic rx_dma_word_i, // pulse: dma read a word
  // read dma memory master (simple request/ack)
  output logic dma_req_o,
  output logic [31:0] dma_addr_o,
  input wire logic dma_ack_i,
  input wire logic [31:0] dma_rdata_i,
  input wire logic blk_done_i, // pulse: block moved by mover
  output logic blk_start_o,
  output logic [31:0] blk_host_o,
  output logic [31:0] blk_local_o,
  output logic [31:0] blk_len_o,
  output logic dma_busy_o,
  // trigger pin and discrete output
  input wire logic trig_pin_i,
  output logic dscrt_out_o,
  // transmit framing and mode
  output logic [31:0] tx_ctrl_o
);
  logic wr_en; // apb write taken this edge
  logic [31:0] tx_ctrl; // stored writable fields
  logic [TX_AW-1:0] tx_latch; // transmit start address latch
  logic [TX_AW-1:0] tx_io_cnt; // next word to fetch
  logic [TX_AW-1:0] tx_dma_cnt; // next dma deposit word
  logic [RX_AW-1:0] rx_io_cnt; // next word to write
  logic [RX_AW-1:0] rx_dma_cnt; // next dma read word
  logic [CW-1:0] hmax, hmin, lmax, lmin; // trigger limits
  logic [CW-1:0] dly, per, duty; // pulse parameters
  logic [CW-1:0] high_cnt, low_cnt;
  logic [3:0] trig_flags;
  logic trig_s1, trig_s2, trig_s3; // pin synchroniser plus history
  logic [$clog2(BDIV)-1:0] div_cnt;
  logic tick_b; // pll clock b rate enable
  logic clr_flags;
  logic pg_active;
  ucar_dma_state_t dma_state;
  logic [1:0] word_idx; // descriptor word being fetched
  logic [31:0] next_ptr;

  // strobe helper: one latch bit, used for every strobed port
  function automatic logic strobe(input logic [31:0] d, input int b);
    strobe = d[b];
  endfunction

  assign wr_en = psel_i && penable_i && pwrite_i;

  // apb answer: zero wait states, no error for any address
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
    end
  end

  // read mux, registered in the setup cycle; unmapped reads zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        `UCAR_OFS_TX_RAM_OFFSETS: prdata_o <= 32'(tx_dma_cnt) << `UCAR_TXO_DMA_LSB | 32'(tx_io_cnt);
        `UCAR_OFS_DMA_PTR: prdata_o <= 32'(rx_dma_cnt) << `UCAR_RXO_DMA_LSB | 32'(rx_io_cnt);
        `UCAR_OFS_TRIG: prdata_o <= 32'(trig_s2) << `UCAR_LEVEL_BIT | 32'(high_cnt);
        `UCAR_OFS_PULSE: prdata_o <= 32'(trig_s2) << `UCAR_LEVEL_BIT | 32'(low_cnt);
        `UCAR_OFS_TX_CTRL: prdata_o <= tx_ctrl | 32'(tx_enabled_i);
        `UCAR_OFS_DMA_STATUS: prdata_o <= 32'(dma_busy_o);
        `UCAR_OFS_TRIG_STATUS: prdata_o <= 32'(trig_flags);
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // transmit control, bit 0 is never stored
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ctrl <= `UCAR_TXC_RESET;
    end else if (wr_en && paddr_i == `UCAR_OFS_TX_CTRL) begin
      tx_ctrl <= pwdata_i & `UCAR_TXC_WR_MASK;
    end
  end

  // transmit ram pointers; latch reloads counter on every message
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_latch <= '0;
      tx_io_cnt <= '0;
      tx_dma_cnt <= '0;
    end else begin
      if (wr_en && paddr_i == `UCAR_OFS_START_ADDR && strobe(pwdata_i, `UCAR_ADDR_TX_STB)) begin
        tx_latch <= pwdata_i[TX_AW-1:0];
      end
      if (tx_msg_start_i) begin
        tx_io_cnt <= tx_latch;
      end else if (tx_word_fetch_i) begin
        tx_io_cnt <= tx_io_cnt + 1'b1;
      end
      if (tx_dma_word_i) begin
        tx_dma_cnt <= tx_dma_cnt + 1'b1;
      end
    end
  end

  // receive ram pointers; status word and data share the increment
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_io_cnt <= '0;
      rx_dma_cnt <= '0;
    end else begin
      if (wr_en && paddr_i == `UCAR_OFS_START_ADDR && strobe(pwdata_i, `UCAR_ADDR_RX_STB)) begin
        rx_io_cnt <= pwdata_i[RX_AW-1:0];
      end else if (rx_word_wr_i) begin
        rx_io_cnt <= rx_io_cnt + 1'b1;
      end
      if (rx_dma_word_i) begin
        rx_dma_cnt <= rx_dma_cnt + 1'b1;
      end
    end
  end

  assign tx_io_addr_o = tx_io_cnt;
  assign rx_io_addr_o = rx_io_cnt;
  assign tx_ctrl_o = tx_ctrl;

  // trigger limits; each strobe owns one limit
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hmax <= `UCAR_CNT_RESET;
      hmin <= `UCAR_CNT_RESET;
      lmax <= `UCAR_CNT_RESET;
      lmin <= `UCAR_CNT_RESET;
    end else if (wr_en && paddr_i == `UCAR_OFS_TRIG) begin
      if (strobe(pwdata_i, `UCAR_TRIG_HMAX_STB)) hmax <= pwdata_i[CW-1:0];
      if (strobe(pwdata_i, `UCAR_TRIG_HMIN_STB)) hmin <= pwdata_i[CW-1:0];
      if (strobe(pwdata_i, `UCAR_TRIG_LMAX_STB)) lmax <= pwdata_i[CW-1:0];
      if (strobe(pwdata_i, `UCAR_TRIG_LMIN_STB)) lmin <= pwdata_i[CW-1:0];
    end
  end

  // pulse parameters
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly <= `UCAR_CNT_RESET;
      per <= `UCAR_CNT_RESET;
      duty <= `UCAR_CNT_RESET;
    end else if (wr_en && paddr_i == `UCAR_OFS_PULSE) begin
      if (strobe(pwdata_i, `UCAR_PULSE_DLY_STB)) dly <= pwdata_i[CW-1:0];
      if (strobe(pwdata_i, `UCAR_PULSE_PER_STB)) per <= pwdata_i[CW-1:0];
      if (strobe(pwdata_i, `UCAR_PULSE_DUTY_STB)) duty <= pwdata_i[CW-1:0];
    end
  end

  // flags clear on a status write with any data; a set still wins
  assign clr_flags = wr_en && paddr_i == `UCAR_OFS_TRIG_STATUS;

  // pll clock b stand-in: one-cycle enable every BDIV cycles
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= '0;
      tick_b <= 1'b0;
    end else begin
      tick_b <= (div_cnt == '0);
      div_cnt <= (int'(div_cnt) == BDIV - 1) ? '0 : div_cnt + 1'b1;
    end
  end

  // trigger pin synchroniser; only stage two onward is read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trig_pin_i;
      trig_s2 <= trig_s1;
      if (tick_b) trig_s3 <= trig_s2;
    end
  end

  ucar_trig_mon #(.CW(CW)) u_mon (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick_b),
    .trig_i(trig_s2),
    .clear_flags_i(clr_flags),
    .hmax_i(hmax),
    .hmin_i(hmin),
    .lmax_i(lmax),
    .lmin_i(lmin),
    .high_cnt_o(high_cnt),
    .low_cnt_o(low_cnt),
    .flags_o(trig_flags)
  );

  ucar_pulse_gen #(.CW(CW)) u_pg (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick_b),
    .enable_i(tx_ctrl[10]),
    .trig_edge_i(tx_ctrl[11] ? (trig_s2 && !trig_s3) : (!trig_s2 && trig_s3)),
    .mode_i(tx_ctrl[14:13]),
    .delay_i(dly),
    .period_i(per),
    .duty_i(duty),
    .active_o(pg_active)
  );

  // output polarity and steady-level override, registered
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dscrt_out_o <= 1'b1;
    end else if (tx_ctrl[15]) begin
      dscrt_out_o <= !tx_ctrl[12];
    end else begin
      dscrt_out_o <= pg_active ~^ tx_ctrl[12];
    end
  end

  // read dma chain walker: fetch four words, hand block, follow next
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_state <= UCAR_DMA_IDLE;
      word_idx <= 2'd0;
      dma_req_o <= 1'b0;
      dma_addr_o <= 32'h0000_0000;
      blk_start_o <= 1'b0;
      blk_host_o <= 32'h0000_0000;
      blk_local_o <= 32'h0000_0000;
      blk_len_o <= 32'h0000_0000;
      next_ptr <= 32'h0000_0000;
    end else begin
      blk_start_o <= 1'b0;
      if (wr_en && paddr_i == `UCAR_OFS_DMA_PTR) begin
        dma_req_o <= (pwdata_i != 32'h0000_0000);
        dma_addr_o <= pwdata_i;
        word_idx <= 2'd0;
        dma_state <= (pwdata_i != 32'h0000_0000) ? UCAR_DMA_DESC : UCAR_DMA_IDLE;
      end else begin
        unique case (dma_state)
          UCAR_DMA_IDLE: dma_req_o <= 1'b0;
          UCAR_DMA_DESC: begin
            if (dma_ack_i) begin
              // word order fixed by word_idx: host, local, length, next
              unique case (word_idx)
                2'd0: blk_host_o <= dma_rdata_i;
                2'd1: blk_local_o <= dma_rdata_i;
                2'd2: blk_len_o <= dma_rdata_i;
                2'd3: next_ptr <= dma_rdata_i;
              endcase
              word_idx <= word_idx + 1'b1;
              dma_addr_o <= dma_addr_o + 32'h0000_0004;
              if (word_idx == 2'd3) begin
                dma_req_o <= 1'b0;
                blk_start_o <= 1'b1;
                dma_state <= UCAR_DMA_BLOCK;
              end
            end
          end
          UCAR_DMA_BLOCK: begin
            if (blk_done_i) begin
              if (next_ptr[`UCAR_DESC_EOC_BIT]) begin
                dma_state <= UCAR_DMA_IDLE;
              end else begin
                dma_addr_o <= {next_ptr[31:1], 1'b0};
                dma_req_o <= 1'b1;
                word_idx <= 2'd0;
                dma_state <= UCAR_DMA_DESC;
              end
            end
          end
          UCAR_DMA_WAIT: dma_state <= UCAR_DMA_IDLE;
        endcase
      end
    end
  end

  assign dma_busy_o = (dma_state != UCAR_DMA_IDLE);

  a_zero_abort: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_en && paddr_i == `UCAR_OFS_DMA_PTR && pwdata_i == 32'h0000_0000) |=> !dma_busy_o && !dma_req_o)
    else $error("zero pointer did not abort");
  a_start_fetch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_en && paddr_i == `UCAR_OFS_DMA_PTR && pwdata_i != 32'h0000_0000) |=> dma_req_o && dma_addr_o == $past(pwdata_i))
    else $error("pointer write did not start fetch");
  a_tx_reload: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_msg_start_i |=> tx_io_cnt == $past(tx_latch)) else $error("tx counter not reloaded");
  a_rx_load: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_en && paddr_i == `UCAR_OFS_START_ADDR && pwdata_i[16]) |=> rx_io_cnt == $past(pwdata_i[RX_AW-1:0]))
    else $error("rx address not loaded");
  a_ctrl_bit0: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == `UCAR_OFS_TX_CTRL) |=>
    prdata_o[0] == $past(tx_enabled_i) && !tx_ctrl[0]) else $error("read-only bit wrong");
  a_no_strobe: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_en && paddr_i == `UCAR_OFS_TRIG && pwdata_i[25:22] == 4'h0) |=> $stable(hmax) && $stable(lmin))
    else $error("limit changed without strobe");
  c_chain_end: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    dma_state == UCAR_DMA_BLOCK && blk_done_i && next_ptr[0]);
  c_abort: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    dma_busy_o && wr_en && paddr_i == `UCAR_OFS_DMA_PTR && pwdata_i == 32'h0000_0000);
  c_flag_set: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(trig_flags[0]));
endmodule // ucar_regs

//--- src/ucar_trig_mon.sv
// trigger duration monitor running on the pll clock b enable
`timescale 1ns/10ps
`include "ucar_regs.svh"
module ucar_trig_mon import ucar_pkg::*; #(
  parameter int CW = 22
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire logic trig_i,
  input wire logic clear_flags_i,
  input wire logic [CW-1:0] hmax_i,
  input wire logic [CW-1:0] hmin_i,
  input wire logic [CW-1:0] lmax_i,
  input wire logic [CW-1:0] lmin_i,
  output logic [CW-1:0] high_cnt_o,
  output logic [CW-1:0] low_cnt_o,
  output logic [3:0] flags_o
);
  logic trig_q; // level at last tick, for edge detect
  logic [CW-1:0] run_cnt; // duration of current level
  logic fall;
  logic rise;
  assign rise = tick_i && trig_i && !trig_q;
  assign fall = tick_i && !trig_i && trig_q;

  // run counter saturates rather than wrapping on a stuck input
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_q <= 1'b0;
      run_cnt <= `UCAR_CNT_RESET;
    end else if (tick_i) begin
      trig_q <= trig_i;
      if (rise || fall) begin
        run_cnt <= {{(CW-1){1'b0}}, 1'b1};
      end else if (run_cnt != {CW{1'b1}}) begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

  // captured durations of the finished levels
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_cnt_o <= `UCAR_CNT_RESET;
      low_cnt_o <= `UCAR_CNT_RESET;
    end else begin
      if (fall) begin
        high_cnt_o <= run_cnt;
      end
      if (rise) begin
        low_cnt_o <= run_cnt;
      end
    end
  end

  // sticky flags: hmax, hmin, lmax, lmin; a set wins over a clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_o <= 4'h0;
    end else begin
      flags_o <= (clear_flags_i ? 4'h0 : flags_o) | {
        fall && run_cnt > hmax_i, fall && run_cnt < hmin_i,
        rise && run_cnt > lmax_i, rise && run_cnt < lmin_i};
    end
  end

  a_high_capture: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    fall |=> high_cnt_o == $past(run_cnt)) else $error("high duration not captured");
  a_over_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (fall && run_cnt > hmax_i) |=> flags_o[3]) else $error("high over flag missed");
endmodule // ucar_trig_mon
